// *** design/thermal_cmd_slave.sv ***
// Purpose: Bus slave command interpreter of a digital temperature sensor
// Assumes: SCL and SDA are open-drain pins sampled by the 250 MHz core clock
// Notes:   The sensor front end delivers temp_sample; conversion is a timer here
// Contract
// (RQ1) Answer only the configured 7-bit address, one of two variant values.
// (RQ2) Host sets direction bit one for reads, zero for writes.
// (RQ3) Command byte starts a measurement, selecting clock hold or polling mode.
// (RQ4) Decode single-byte configuration write, configuration read and soft reset.
// (RQ5) Decode two-byte commands for both serial halves and firmware revision.
// (RQ6) Host never sends undefined command codes.
// (RQ7) Hold mode keeps SCL low while converting, releases once result is ready.
// (RQ8) Polling mode refuses read address until conversion ends; host retries.
// (RQ9) Checksum follows low result byte only when host acknowledges it.
// (RQ10) Checksum is CRC-8, polynomial x^8+x^5+x^4+1, starting from zero.
// (RQ11) Serial reads carry checksums; register and revision reads never do.
// (RQ12) Low result byte always ends in two zero bits.
// (RQ13) Result is a 16-bit code sent high byte first; host scales it.
// (RQ14) Register read: write command, repeated start, read one byte, host refuses.
// (RQ15) Register write: write address, command byte, data byte, all acknowledged.
// (RQ16) First serial access sends byte, checksum pairs; second sends pairs, checksum.
// (RQ17) Serial identifier is eight bytes, first access high half, MSB first.
// (RQ18) Top byte of second serial half holds the part identification code.
// (RQ19) Revision read: two-byte command, repeated start, one byte, host refuses.
// (RQ20) Resolution from bits seven and zero: 14, 12, 13, 11 bits.
// (RQ21) Bit six is read-only supply status, one meaning supply low.
// (RQ22) Reserved bits keep their value and ignore writes; host writes back.
// (RQ23) Soft reset restores configuration and abandons any running conversion.

`timescale 1ns/1ps
`default_nettype none

module thermal_cmd_slave
  import thermal_cmd_pkg::*;
#(
  parameter logic [6:0]  dev_addr        = addr_base,
  parameter int          conv_cycles     = conv_cycles_dft,
  parameter logic [31:0] serial_high_half_bytes = 32'h1234_5678,
  parameter logic [7:0]  part_identification_byte = 8'h5A,
  parameter logic [23:0] serial_low_rest = 24'h9A_BCDE,
  parameter logic [7:0]  firmware_revision_byte = 8'h11
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [15:0] temp_sample,
  input  wire logic        supply_low_in,
  output logic             measure_busy
);

  // Counter wide enough for the conversion and the data setup wait
  localparam int CW = $clog2(conv_cycles + su_cycles + 1);
  typedef logic [CW-1:0] cnt_t;

  // Part code and revision defaults above are arbitrary neutral values
  localparam logic [31:0] serial_low_half_bytes = {part_identification_byte, serial_low_rest}; // RQ18

  if (!(dev_addr == addr_base || dev_addr == addr_alt)) begin : g_bad_addr
    $error("thermal_cmd_slave: address must be one of the two variant values");
  end
  if (conv_cycles < 1) begin : g_bad_conv
    $error("thermal_cmd_slave: conversion needs at least one cycle");
  end

  typedef enum logic [5:0] {
    st_idle  = 6'h01,
    st_addr  = 6'h02,
    st_cmd1  = 6'h04,
    st_cmd2  = 6'h08,
    st_wdata = 6'h10,
    st_tx    = 6'h20,
    st_hold  = 6'h00 | 6'h00
  } phase_tmp_e;

  typedef enum logic [6:0] {
    ph_idle  = 7'h01,
    ph_addr  = 7'h02,
    ph_cmd1  = 7'h04,
    ph_cmd2  = 7'h08,
    ph_wdata = 7'h10,
    ph_tx    = 7'h20,
    ph_hold  = 7'h40
  } phase_e;

  typedef enum logic [5:0] {
    kind_none = 6'h01,
    kind_meas = 6'h02,
    kind_reg  = 6'h04,
    kind_sa   = 6'h08,
    kind_sb   = 6'h10,
    kind_fw   = 6'h20
  } kind_e;

  typedef struct packed {
    logic       scl_m;
    logic       scl_s;
    logic       scl_d;
    logic       sda_m;
    logic       sda_s;
    logic       sda_d;
    logic       sup_m;
    logic       sup_s;
    phase_e     ph;
    logic       ack_ph;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] first_cmd;
    logic [7:0] txb;
    logic [7:0] crc;
    logic       mack;
    logic       sda_drv;
    logic       scl_drv;
    kind_e      kind;
    logic       hold_mode;
    logic       busy;
    cnt_t       cnt;
    logic [15:0] result;
    logic [1:0] res;
    logic [2:0] idx;
  } state_s;

  state_s s;
  state_s n;

  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       poll_busy;
  logic       addr_dec;
  logic       cmd_exec;
  logic       wdata_exec;
  logic [7:0] cfg_value;
  logic [2:0] sel_idx;
  logic [7:0] crc_base;
  logic [8:0] pick;
  logic [7:0] load_byte;
  logic [7:0] crc_next;
  logic [7:0] load_crc;

  // Result bits below the selected resolution read as zero; two LSBs always do
  function automatic logic [15:0] res_mask(input logic [1:0] r);
    unique case (r)
      res_14:  res_mask = 16'hFFFC; // RQ20 RQ12
      res_13:  res_mask = 16'hFFF8; // RQ20
      res_12:  res_mask = 16'hFFF0; // RQ20
      default: res_mask = 16'hFFE0; // RQ20
    endcase
  endfunction : res_mask

  // Answer byte per transfer kind and index; bit 8 marks a checksum slot
  function automatic logic [8:0] pick_byte(input kind_e k, input logic [2:0] i,
                                           input logic [15:0] r, input logic [7:0] cfg);
    pick_byte = {1'b0, 8'hFF};
    unique case (k)
      kind_meas: begin
        if (i == 3'h0) pick_byte = {1'b0, r[15:8]}; // RQ13
        else if (i == 3'h1) pick_byte = {1'b0, r[7:0]};
        else pick_byte = {1'b1, 8'h00}; // RQ9
      end
      kind_reg:  pick_byte = {1'b0, cfg}; // RQ11 RQ14
      kind_fw:   pick_byte = {1'b0, firmware_revision_byte}; // RQ11 RQ19
      kind_sa: begin
        if (i[0]) pick_byte = {1'b1, 8'h00}; // RQ16
        else pick_byte = {1'b0, serial_high_half_bytes[{2'h3 - i[2:1], 3'h0} +: 8]}; // RQ17
      end
      kind_sb: begin
        unique case (i)
          3'h0:    pick_byte = {1'b0, serial_low_half_bytes[31:24]}; // RQ17
          3'h1:    pick_byte = {1'b0, serial_low_half_bytes[23:16]};
          3'h3:    pick_byte = {1'b0, serial_low_half_bytes[15:8]};
          3'h4:    pick_byte = {1'b0, serial_low_half_bytes[7:0]};
          default: pick_byte = {1'b1, 8'h00}; // RQ16
        endcase
      end
      default:   pick_byte = {1'b0, 8'hFF};
    endcase
  endfunction : pick_byte

  function automatic logic [2:0] last_idx(input kind_e k);
    unique case (k)
      kind_meas: last_idx = last_meas;
      kind_sa:   last_idx = last_sa;
      kind_sb:   last_idx = last_sb;
      default:   last_idx = last_single;
    endcase
  endfunction : last_idx

  // Bus events from the synchronised pins; only second and third stage are read
  assign rise      = s.scl_s & ~s.scl_d;
  assign fall      = ~s.scl_s & s.scl_d;
  assign start     = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
  assign stop      = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;
  assign poll_busy = (s.kind == kind_meas) & ~s.hold_mode & s.busy;
  assign addr_dec  = fall & ~start & ~stop & (s.ph == ph_addr) & ~s.ack_ph & (s.bitcnt == byte_bits);
  assign cmd_exec  = fall & ~start & ~stop & (s.ph == ph_cmd1) & s.ack_ph;
  assign wdata_exec = fall & ~start & ~stop & (s.ph == ph_wdata) & s.ack_ph;

  // Reserved bits are constants, so writes cannot reach them
  assign cfg_value = {s.res[1], s.sup_s, reserved_bits, s.res[0]}; // RQ21 RQ22

  // Next answer byte; the checksum restarts from zero for each read
  assign sel_idx   = (s.ph == ph_tx) ? s.idx + 3'h1 : 3'h0;
  assign crc_base  = (s.ph == ph_tx) ? s.crc : crc_init; // RQ10
  assign pick      = pick_byte(s.kind, sel_idx, s.result, cfg_value);
  assign load_byte = pick[8] ? crc_base : pick[7:0]; // RQ11
  assign load_crc  = pick[8] ? crc_base : crc_next;

  crc8_step #(
    .poly    (crc_poly)
  ) u_crc (
    .crc_in  (crc_base),
    .data    (pick[7:0]),
    .crc_out (crc_next) // RQ10
  );

  // Whole next state in one place
  always_comb begin
    n = s;
    n.scl_m = scl_in;
    n.scl_s = s.scl_m;
    n.scl_d = s.scl_s;
    n.sda_m = sda_in;
    n.sda_s = s.sda_m;
    n.sda_d = s.sda_s;
    n.sup_m = supply_low_in;
    n.sup_s = s.sup_m;
    // Conversion timer; result captured at the resolution in force at the end
    if (s.busy) begin
      if (s.cnt == '0) begin
        n.busy   = 1'b0;
        n.result = temp_sample & res_mask(s.res); // RQ12 RQ20
      end else begin
        n.cnt = s.cnt - cnt_t'(1);
      end
    end
    if (start) begin
      n.ph      = ph_addr;
      n.bitcnt  = 4'h0;
      n.ack_ph  = 1'b0;
      n.sda_drv = 1'b0;
      n.scl_drv = 1'b0;
    end else if (stop) begin
      n.ph      = ph_idle;
      n.ack_ph  = 1'b0;
      n.sda_drv = 1'b0;
      n.scl_drv = 1'b0;
    end else begin
      unique case (s.ph)
        ph_idle: begin
        end
        ph_addr, ph_cmd1, ph_cmd2, ph_wdata: begin
          if (!s.ack_ph) begin
            if (rise) begin
              n.shreg  = {s.shreg[6:0], s.sda_s};
              n.bitcnt = s.bitcnt + 4'h1;
            end else if (fall && s.bitcnt == byte_bits) begin
              n.bitcnt = 4'h0;
              // A foreign address, or a read while polling, gets no acknowledge
              if (s.ph != ph_addr || (s.shreg[7:1] == dev_addr && !(s.shreg[0] && poll_busy))) begin // RQ1 RQ8
                n.ack_ph  = 1'b1;
                n.sda_drv = 1'b1;
              end else begin
                n.ph = ph_idle;
              end
            end
          end else if (fall) begin
            n.ack_ph  = 1'b0;
            n.sda_drv = 1'b0;
            unique case (s.ph)
              ph_addr: begin
                if (!s.shreg[0]) begin
                  n.ph = ph_cmd1;
                end else if (s.kind == kind_meas && s.busy) begin
                  n.ph      = ph_hold; // RQ7
                  n.scl_drv = 1'b1;
                end else begin
                  n.ph      = ph_tx;
                  n.idx     = sel_idx;
                  n.txb     = load_byte;
                  n.crc     = load_crc;
                  n.sda_drv = ~load_byte[7];
                  n.bitcnt  = 4'h1;
                  n.mack    = 1'b0;
                end
              end
              ph_cmd1: begin
                n.ph = ph_idle;
                if (s.shreg == cmd_meas_hold || s.shreg == cmd_meas_poll) begin
                  n.kind      = kind_meas; // RQ3
                  n.hold_mode = (s.shreg == cmd_meas_hold);
                  n.busy      = 1'b1;
                  n.cnt       = cnt_t'(conv_cycles - 1);
                end else if (s.shreg == cmd_soft_reset) begin
                  n.res  = cfg_res_reset; // RQ4 RQ23
                  n.busy = 1'b0;
                  n.kind = kind_none;
                end else if (s.shreg == cmd_cfg_write) begin
                  n.ph = ph_wdata; // RQ4 RQ15
                end else if (s.shreg == cmd_cfg_read) begin
                  n.kind = kind_reg; // RQ4
                end else if (s.shreg == cmd_sa_first || s.shreg == cmd_sb_first || s.shreg == cmd_fw_first) begin
                  n.first_cmd = s.shreg; // RQ5
                  n.ph        = ph_cmd2;
                end else begin
                  n.kind = kind_none;
                end
              end
              ph_cmd2: begin
                n.ph = ph_idle;
                if (s.first_cmd == cmd_sa_first && s.shreg == cmd_sa_second) n.kind = kind_sa; // RQ5
                else if (s.first_cmd == cmd_sb_first && s.shreg == cmd_sb_second) n.kind = kind_sb;
                else if (s.first_cmd == cmd_fw_first && s.shreg == cmd_fw_second) n.kind = kind_fw;
                else n.kind = kind_none;
              end
              default: begin
                n.ph  = ph_idle;
                n.res = {s.shreg[cfg_res_hi_bit], s.shreg[cfg_res_lo_bit]}; // RQ15 RQ20 RQ22
              end
            endcase
          end
        end
        ph_tx: begin
          if (!s.ack_ph) begin
            if (fall) begin
              if (s.bitcnt == byte_bits) begin
                n.sda_drv = 1'b0;
                n.ack_ph  = 1'b1;
              end else begin
                n.sda_drv = ~s.txb[3'h7 - s.bitcnt[2:0]];
                n.bitcnt  = s.bitcnt + 4'h1;
              end
            end
          end else if (rise) begin
            n.mack = ~s.sda_s;
          end else if (fall) begin
            n.ack_ph = 1'b0;
            // Another byte only after an acknowledge; a refusal ends the read
            if (s.mack && s.idx != last_idx(s.kind)) begin // RQ9 RQ16
              n.idx     = sel_idx;
              n.txb     = load_byte;
              n.crc     = load_crc;
              n.sda_drv = ~load_byte[7];
              n.bitcnt  = 4'h1;
              n.mack    = 1'b0;
            end else begin
              n.ph = ph_idle;
            end
          end
        end
        ph_hold: begin
          // Put the first bit out, then give it the setup time before releasing SCL
          if (s.busy) begin
            n.scl_drv = 1'b1; // RQ7
          end else if (!s.ack_ph) begin
            n.ack_ph  = 1'b1;
            n.idx     = sel_idx;
            n.txb     = load_byte;
            n.crc     = load_crc;
            n.sda_drv = ~load_byte[7];
            n.bitcnt  = 4'h1;
            n.mack    = 1'b0;
            n.cnt     = cnt_t'(su_cycles);
          end else if (s.cnt == '0) begin
            n.scl_drv = 1'b0; // RQ7
            n.ack_ph  = 1'b0;
            n.ph      = ph_tx;
          end else begin
            n.cnt = s.cnt - cnt_t'(1);
          end
        end
        default: begin
          n.ph = ph_idle;
        end
      endcase
    end
  end

  // Pins idle high in the synchronisers so release does not look like a start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s       <= '0;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_d <= 1'b1;
      s.ph    <= ph_idle;
      s.kind  <= kind_none;
      s.res   <= cfg_res_reset;
    end else begin
      s <= n;
    end
  end

  // Open-drain outputs only ever pull low
  assign scl_out      = 1'b0;
  assign sda_out      = 1'b0;
  assign scl_oe_n     = ~s.scl_drv;
  assign sda_oe_n     = ~s.sda_drv;
  assign measure_busy = s.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_addr_foreign_nack: assert property (addr_dec && s.shreg[7:1] != dev_addr |=> !s.sda_drv && s.ph == ph_idle) // RQ1
    else $error("foreign address was acknowledged");
  a_poll_busy_nack: assert property (addr_dec && s.shreg[7:1] == dev_addr && s.shreg[0] && poll_busy |=> !s.sda_drv ##1 !s.sda_drv) // RQ8
    else $error("read address acknowledged during polled conversion");
  a_meas_start_mode: assert property (cmd_exec && (s.shreg == cmd_meas_hold || s.shreg == cmd_meas_poll)
                                      |=> s.busy && s.kind == kind_meas && s.hold_mode == ($past(s.shreg) == cmd_meas_hold)) // RQ3
    else $error("measurement command did not start the right mode");
  a_soft_reset_cfg: assert property (cmd_exec && s.shreg == cmd_soft_reset |=> !s.busy && s.res == cfg_res_reset) // RQ23
    else $error("soft reset left configuration or conversion");
  a_cfg_write_res: assert property (wdata_exec |=> s.res == {$past(s.shreg[7]), $past(s.shreg[0])}) // RQ15
    else $error("configuration write did not land in resolution bits");
  a_hold_stretch_low: assert property (s.ph == ph_hold && s.busy |=> s.scl_drv) // RQ7
    else $error("clock released while conversion runs");
  a_hold_release_time: assert property (s.ph == ph_hold && $fell(s.busy) |-> ##[25:28] !s.scl_drv) // RQ7
    else $error("clock not released after conversion");
  a_result_low_zero: assert property (!s.busy |-> s.result[1:0] == 2'h0) // RQ12
    else $error("result low bits not zero");
  a_nack_ends_read: assert property (s.ph == ph_tx && s.ack_ph && fall && !s.mack && !start && !stop
                                     |=> s.ph == ph_idle && !s.sda_drv) // RQ9
    else $error("read continued after host refusal");

  c_hold_stretch: cover property (s.ph == ph_hold && s.busy ##1 !s.busy);
  c_poll_refused: cover property (addr_dec && s.shreg[0] && poll_busy);
  c_serial_a_done: cover property (s.kind == kind_sa && s.idx == last_sa && s.ph == ph_tx);
  c_cfg_written: cover property (wdata_exec);

endmodule : thermal_cmd_slave

`default_nettype wire

// *** design/thermal_cmd_pkg.sv ***
// Purpose: Shared constants for the thermal sensor command slave
// Assumes: Bus address, command codes and register layout as used by the host
// Notes:   Times are kept in ns and turned into cycles at the 4 ns clock

package thermal_cmd_pkg;

  // Bus addresses of the two ordered variants
  localparam logic [6:0] addr_base       = 7'h40;
  localparam logic [6:0] addr_alt        = 7'h70;

  // Single-byte commands
  localparam logic [7:0] cmd_meas_hold   = 8'hE3;
  localparam logic [7:0] cmd_meas_poll   = 8'hF3;
  localparam logic [7:0] cmd_soft_reset  = 8'hFE;
  localparam logic [7:0] cmd_cfg_write   = 8'hE6;
  localparam logic [7:0] cmd_cfg_read    = 8'hE7;

  // Two-byte commands, first and second byte
  localparam logic [7:0] cmd_sa_first    = 8'hFA;
  localparam logic [7:0] cmd_sa_second   = 8'h0F;
  localparam logic [7:0] cmd_sb_first    = 8'hFC;
  localparam logic [7:0] cmd_sb_second   = 8'hC9;
  localparam logic [7:0] cmd_fw_first    = 8'h84;
  localparam logic [7:0] cmd_fw_second   = 8'hB8;

  // Configuration register layout and value after reset
  localparam logic [7:0] cfg_reset       = 8'h3A;
  localparam int         cfg_res_hi_bit  = 7;
  localparam int         cfg_supply_bit  = 6;
  localparam int         cfg_res_lo_bit  = 0;
  localparam logic [1:0] cfg_res_reset   = {cfg_reset[cfg_res_hi_bit], cfg_reset[cfg_res_lo_bit]};
  localparam logic [4:0] reserved_bits   = cfg_reset[5:1];

  // Resolution codes {bit7, bit0}
  localparam logic [1:0] res_14          = 2'h0;
  localparam logic [1:0] res_12          = 2'h1;
  localparam logic [1:0] res_13          = 2'h2;
  localparam logic [1:0] res_11          = 2'h3;

  // Checksum generator x^8+x^5+x^4+1, cleared before the first byte
  localparam logic [7:0] crc_poly        = 8'h31;
  localparam logic [7:0] crc_init        = 8'h00;

  // Last byte index of each read answer
  localparam logic [2:0] last_meas       = 3'h2;
  localparam logic [2:0] last_sa         = 3'h7;
  localparam logic [2:0] last_sb         = 3'h5;
  localparam logic [2:0] last_single     = 3'h0;

  // Bit count of one byte on the wire
  localparam logic [3:0] byte_bits       = 4'h8;

  // Timing: clock period, data setup before a released clock, conversion
  localparam int         clk_period_ns   = 4;
  localparam int         t_su_dat_ns     = 100;
  localparam int         su_cycles       = (t_su_dat_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int         t_conv_ns       = 10000;
  localparam int         conv_cycles_dft = t_conv_ns / clk_period_ns;

endpackage : thermal_cmd_pkg

// *** design/crc8_step.sv ***
// Purpose: One-byte step of the result checksum, MSB first
// Assumes: Caller holds the running value and feeds one byte at a time
// Notes:   Purely combinational; eight shifts unrolled by the loop

`timescale 1ns/1ps
`default_nettype none

module crc8_step
  import thermal_cmd_pkg::*;
#(
  parameter logic [7:0] poly = crc_poly
) (
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data,
  output logic      [7:0] crc_out
);

  logic [7:0] c;

  // An even polynomial would drop the x^0 term and break the check
  if (poly[0] != 1'b1) begin : g_bad_poly
    $error("crc8_step: polynomial must have the x^0 term");
  end

  // Shift the byte through the generator, one bit per pass
  always_comb begin
    c = crc_in ^ data;
    for (int k = 0; k < 8; k++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ poly) : {c[6:0], 1'b0};
    end
    crc_out = c;
  end

endmodule : crc8_step

`default_nettype wire

// *** tb/i2c_host.sv ***
// Purpose: Behavioural bus master for the sensor slave
// Assumes: Lines are pulled up, so a released line reads high
// Notes:   A bit is four 40 ns quarters; a stretch is waited out, bounded
`timescale 1ns/1ps
`default_nettype none
module i2c_host (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      m_scl,
  output logic      m_sda
);
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  // One quarter of the 160 ns bit period
  task automatic q;
    repeat (10) @(negedge clk);
  endtask : q
  // Start or repeated start: SDA falls while SCL is high
  task automatic start;
    m_sda = 1'b1;
    q;
    m_scl = 1'b1;
    q;
    m_sda = 1'b0;
    q;
    m_scl = 1'b0;
  endtask : start
  task automatic stop;
    q;
    m_sda = 1'b0;
    q;
    m_scl = 1'b1;
    q;
    m_sda = 1'b1;
    q;
  endtask : stop
  // Data changes only while SCL is low; sample mid-high after any stretch
  task automatic bit_io(input logic b, output logic r);
    int n;
    q;
    m_sda = b;
    q;
    m_scl = 1'b1;
    for (n = 0; n < 20000 && scl !== 1'b1; n++) @(negedge clk);
    q;
    r = sda;
    q;
    m_scl = 1'b0;
  endtask : bit_io
  // Byte plus acknowledge bit; tx is all ones when reading
  task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic ar);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ak, ar);
  endtask : xfer
endmodule : i2c_host
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the thermal sensor command slave
// Assumes: Conversion shortened to 1000 cycles; lines are wired-AND
// Notes:   Serial checksums run over all data bytes of one read
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import thermal_cmd_pkg::*;
  logic        clk, rstn, supply_low_in, m_scl, m_sda, scl, sda, scl_oe_n, sda_oe_n, stretched, ak, busy;
  logic [15:0] temp_sample;
  logic [7:0]  rx, c;
  int          err_total, n_checks, cyc;
  // Either party may pull a line low
  assign scl = m_scl & scl_oe_n;
  assign sda = m_sda & sda_oe_n;
  thermal_cmd_slave #(.conv_cycles(1000)) i_thermal_cmd_slave (.clk(clk), .rstn(rstn), .scl_in(scl),
    .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n),
    .temp_sample(temp_sample), .supply_low_in(supply_low_in), .measure_busy(busy));
  i2c_host i_i2c_host (.clk(clk), .scl(scl), .sda(sda), .m_scl(m_scl), .m_sda(m_sda));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cycle ceiling cuts a hang short; also notes any clock stretch
  always @(posedge clk) begin
    cyc++;
    if (!scl_oe_n) stretched = 1'b1;
    if (cyc == 60000) begin
      err_total++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] crc(input logic [7:0] r, input logic [7:0] d);
    r ^= d;
    for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h31 : {r[6:0], 1'b0};
    return r;
  endfunction : crc
  // Bus helpers: write with expected acknowledge, read with own acknowledge
  task automatic wr(input logic [7:0] b, input logic e);
    i_i2c_host.xfer(b, 1'b1, rx, ak);
    chk({7'h0, ak}, {7'h0, e});
  endtask : wr
  task automatic rd(input logic [7:0] e, input logic last);
    i_i2c_host.xfer(8'hFF, last, rx, ak);
    chk(rx, e);
  endtask : rd
  task automatic cmd(input logic [7:0] c1, input logic [7:0] c2, input logic two);
    i_i2c_host.start;
    wr({addr_base, 1'b0}, 1'b0);
    wr(c1, 1'b0);
    if (two) wr(c2, 1'b0);
  endtask : cmd
  task automatic rsel(input logic e);
    i_i2c_host.start;
    wr({addr_base, 1'b1}, e);
  endtask : rsel
  task automatic t_cfg;
    cmd(cmd_cfg_read, 8'h00, 1'b0);
    rsel(1'b0);
    rd(8'h3A, 1'b1);
    i_i2c_host.stop;
    cmd(cmd_cfg_write, 8'h00, 1'b0);
    wr(8'h81, 1'b0);
    i_i2c_host.stop;
    supply_low_in = 1'b1;
    cmd(cmd_cfg_read, 8'h00, 1'b0);
    rsel(1'b0);
    rd(8'hFB, 1'b1);
    i_i2c_host.stop;
  endtask : t_cfg
  // Polled conversion at 11 bits: refused until done, no checksum after NACK
  task automatic t_poll;
    cmd(cmd_meas_poll, 8'h00, 1'b0);
    rsel(1'b1);
    for (int n = 0; n < 10 && ak !== 1'b0; n++) begin
      i_i2c_host.stop;
      i_i2c_host.start;
      i_i2c_host.xfer({addr_base, 1'b1}, 1'b1, rx, ak);
    end
    chk({7'h0, ak}, 8'h00);
    rd(8'hAB, 1'b0);
    rd(8'hC0, 1'b1);
    i_i2c_host.stop;
    chk({7'h0, busy}, 8'h00);
  endtask : t_poll
  task automatic t_reset;
    supply_low_in = 1'b0;
    cmd(cmd_soft_reset, 8'h00, 1'b0);
    i_i2c_host.stop;
    cmd(cmd_cfg_read, 8'h00, 1'b0);
    rsel(1'b0);
    rd(cfg_reset, 1'b1);
    i_i2c_host.stop;
  endtask : t_reset
  task automatic t_hold;
    stretched = 1'b0;
    cmd(cmd_meas_hold, 8'h00, 1'b0);
    rsel(1'b0);
    chk({7'h0, busy}, 8'h01);
    rd(8'hAB, 1'b0);
    rd(8'hCC, 1'b0);
    rd(crc(crc(8'h00, 8'hAB), 8'hCC), 1'b1);
    i_i2c_host.stop;
    chk({7'h0, stretched}, 8'h01);
  endtask : t_hold
  // Half h of the 64-bit identifier; checksum after each byte or byte pair
  task automatic t_serial(input int h);
    logic [63:0] sn;
    sn = 64'h1234_5678_5A9A_BCDE;
    c = 8'h00;
    if (h == 0) cmd(cmd_sa_first, cmd_sa_second, 1'b1);
    else cmd(cmd_sb_first, cmd_sb_second, 1'b1);
    rsel(1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(sn[63-32*h-8*i -: 8], 1'b0);
      c = crc(c, sn[63-32*h-8*i -: 8]);
      if (h == 0 || i % 2 == 1) rd(c, i == 3);
    end
    i_i2c_host.stop;
  endtask : t_serial
  task automatic t_fw;
    cmd(cmd_fw_first, cmd_fw_second, 1'b1);
    rsel(1'b0);
    rd(8'h11, 1'b1);
    i_i2c_host.stop;
    i_i2c_host.start;
    wr({addr_alt, 1'b0}, 1'b1);
    i_i2c_host.stop;
  endtask : t_fw
  task automatic report_and_stop;
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Reset for 20 cycles, then every scenario in turn
  initial begin
    rstn = 1'b0;
    supply_low_in = 1'b0;
    temp_sample = 16'hABCF;
    stretched = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (5) @(negedge clk);
    t_cfg;
    t_poll;
    t_reset;
    t_hold;
    t_serial(0);
    t_serial(1);
    t_fw;
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
